// [src/esc_host.sv]
// Host controller that configures and polls the scrub engine of an error-correcting SRAM
// Behaviour
// [R1] Address bits 10 and 9 are zero throughout every configuration write.
// [R2] Device ignores address bits 18 to 13 during configuration programming.
// [R3] Configuration is undefined at power-up; host must write it first.
// [R4] Host may read the configuration back after the first write.
// [R5] Recommended start: interval code 7, delay code 10, correction and scrub on.
// [R6] Interval codes 0 to 3 unavailable; code 4 upward roughly doubles.
// [R7] Delay code sets maximum warning-to-scrub time, 80 to 1600 ns.
// [R8] Warning-to-scrub delay is never below the stated minimum.
// [R9] Interval between warning falls follows the rate code, above minimum.
// [R10] Scrub pulse low lasts 200 to 504 ns; array not accessible.
// [R11] Warning releases 50 to 120 ns after scrub pulse ends.
// [R12] Chip enable requested scrub lowers warning within 160 ns.
// [R13] Error flag requested scrub lowers warning within 160 ns.
// [R14] Error flag valid no later than 146 ns after scrub falls.
// [R15] Chip enable rising ends requested scrub pulse within 20 ns.
// [R16] Chip enable rising releases warning within 20 ns.
// [R17] Error flag rising releases flag-requested warning within 20 ns.
// [R18] Host strobes error flag high; read data valid within 8.2 ns.
// [R19] Control ops: enables active, output and write enable high, address-coded.
// [R20] Configuration write sets scrub counter to ones; increments per scrub.
// [R21] Counter read returns 19 bits on data lines 18 to 0.
// [R22] Fields: rate 3:0, delay 7:4, bypass 8, scrub off 11, flag type 12.
// [R23] Scrub repeats autonomously when enabled and correction not bypassed.
// [R24] Host starts no array access between warning fall and scrub end.
`timescale 1ns/1ps
`include "esc_defines.svh"
module esc_host (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Device control pins
  output logic chip_select_low_active,
  output logic chip_select_high_active,
  output logic output_enable_n,
  output logic write_enable_n,
  output logic [18:0] addr,
  // Error flag pin, two-way
  input wire logic error_flag_in,
  output logic error_flag_out,
  output logic error_flag_oe_n,
  // Data bus input and scrub status pins
  input wire logic [31:0] dq_in,
  input wire logic scrub_warning_n,
  input wire logic scrub_active_n,
  // Array access hold-off for the system
  output logic array_blocked
);
  esc_pkg::esc_state_reg_type q, d;
  logic setup_phase;
  logic blocked;
  logic wr_access;

  assign setup_phase = psel && !penable;
  // Writes land at the access edge, where pready is sampled high
  assign wr_access = psel && penable && pwrite;
  // Array unusable from warning fall until warning and scrub are both released [R24] [R10]
  assign blocked = !q.w2 || !q.s2;

  always_comb
  begin
    d = q;
    d.w1 = scrub_warning_n;
    d.w2 = q.w1;
    d.s1 = scrub_active_n;
    d.s2 = q.s1;
    d.f1 = error_flag_in;
    d.f2 = q.f1;
    d.d1 = dq_in;
    d.d2 = q.d1;
    if (!q.w2)
    begin
      d.warn_seen = 1'b1;
    end
    if (!q.s2)
    begin
      d.scrub_seen = 1'b1;
    end
    d.prdata_valid = 1'b0;
    if (setup_phase && !pwrite)
    begin
      d.prdata_valid = 1'b1;
      if (paddr == `ESC_OFF_CTRL)
      begin
        d.prdata = 32'h0;
      end
      else if (paddr == `ESC_OFF_CFG)
      begin
        d.prdata = {19'h0, q.cfg};
      end
      else if (paddr == `ESC_OFF_STATUS)
      begin
        d.prdata = {24'h0, q.f2, !q.s2, !q.w2, q.scrub_seen, q.warn_seen, q.rd_valid,
                    q.configured, q.busy};
      end
      else if (paddr == `ESC_OFF_RDATA)
      begin
        d.prdata = q.rdata;
      end
      else
      begin
        d.prdata = 32'h0;
      end
    end
    if (wr_access && paddr == `ESC_OFF_CFG)
    begin
      // Configuration fields taken from write data bits 12:0 [R22]
      d.cfg = pwdata[12:0];
    end
    if (wr_access && paddr == `ESC_OFF_STATUS)
    begin
      // Sticky bits clear on write one, but a live event wins
      if (pwdata[3] && q.w2)
      begin
        d.warn_seen = 1'b0;
      end
      if (pwdata[4] && q.s2)
      begin
        d.scrub_seen = 1'b0;
      end
    end
    case (q.state)
      esc_pkg::ST_IDLE:
      begin
        d.pins.chip_select_low_active = 1'b1;
        d.pins.error_flag_oe_n = 1'b1;
        if (wr_access && paddr == `ESC_OFF_CTRL && !blocked)
        begin
          d.busy = 1'b1;
          d.cnt = 8'h0;
          d.pins.output_enable_n = 1'b1;
          d.pins.write_enable_n = 1'b1;
          d.pins.chip_select_high_active = 1'b1;
          d.pins.chip_select_low_active = 1'b0;
          d.pins.error_flag_out = 1'b0;
          d.pins.error_flag_oe_n = 1'b0;
          d.state = esc_pkg::ST_SETUP;
          if (pwdata[`ESC_CTRL_WRITE_CFG])
          begin
            d.op = 2'd0;
            // Bits 10:9 zero, 18:13 zero as don't care [R1] [R2] [R3]
            d.pins.addr = {6'h0, q.cfg[12:11], 2'b00, q.cfg[8:0]};
          end
          else if (pwdata[`ESC_CTRL_READ_CFG])
          begin
            d.op = 2'd1;
            d.pins.addr = `ESC_A_READ_CFG; // [R4] [R19]
          end
          else if (pwdata[`ESC_CTRL_READ_CNT])
          begin
            d.op = 2'd2;
            d.pins.addr = `ESC_A_READ_CNT; // [R19]
          end
          else
          begin
            d.busy = 1'b0;
            d.pins.chip_select_low_active = 1'b1;
            d.pins.error_flag_oe_n = 1'b1;
            d.state = esc_pkg::ST_IDLE;
          end
        end
      end
      esc_pkg::ST_SETUP:
      begin
        d.cnt = q.cnt + 8'h1;
        if (q.cnt == 8'(`ESC_SETUP_CYC))
        begin
          d.cnt = 8'h0;
          d.pins.error_flag_out = 1'b1; // Strobe rises [R18]
          d.state = esc_pkg::ST_STROBE;
        end
      end
      esc_pkg::ST_STROBE:
      begin
        d.cnt = q.cnt + 8'h1;
        // Wait strobe-to-data plus strobe high time plus two synchroniser stages [R18]
        if (q.cnt == 8'(`ESC_STROBE_CYC + `ESC_HIGH_CYC + 2))
        begin
          if (q.op == 2'd1)
          begin
            d.rdata = {19'h0, q.d2[12:0]};
            d.rd_valid = 1'b1;
          end
          else if (q.op == 2'd2)
          begin
            d.rdata = {13'h0, q.d2[18:0]}; // [R21]
            d.rd_valid = 1'b1;
          end
          else
          begin
            d.configured = 1'b1; // [R20]
          end
          d.cnt = 8'h0;
          d.pins.error_flag_out = 1'b0;
          d.state = esc_pkg::ST_LOW;
        end
      end
      esc_pkg::ST_LOW:
      begin
        d.cnt = q.cnt + 8'h1;
        if (q.cnt == 8'(`ESC_SETUP_CYC))
        begin
          d.pins.chip_select_low_active = 1'b1;
          d.pins.error_flag_oe_n = 1'b1;
          d.state = esc_pkg::ST_DONE;
        end
      end
      default:
      begin
        d.busy = 1'b0;
        d.state = esc_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      q <= '0;
      q.state <= esc_pkg::ST_IDLE;
      q.cfg <= `ESC_CFG_RESET; // [R5]
      q.pins.chip_select_low_active <= 1'b1;
      q.pins.output_enable_n <= 1'b1;
      q.pins.write_enable_n <= 1'b1;
      q.pins.error_flag_oe_n <= 1'b1;
      q.w1 <= 1'b1;
      q.w2 <= 1'b1;
      q.s1 <= 1'b1;
      q.s2 <= 1'b1;
    end
    else
    begin
      q <= d;
    end
  end

  assign prdata = q.prdata;
  assign pready = psel && penable && q.prdata_valid | (psel && penable && pwrite);
  assign pslverr = 1'b0;
  assign chip_select_low_active = q.pins.chip_select_low_active;
  assign chip_select_high_active = q.pins.chip_select_high_active;
  assign output_enable_n = q.pins.output_enable_n;
  assign write_enable_n = q.pins.write_enable_n;
  assign addr = q.pins.addr;
  assign error_flag_out = q.pins.error_flag_out;
  assign error_flag_oe_n = q.pins.error_flag_oe_n;
  assign array_blocked = blocked;
endmodule

// [src/esc_defines.svh]
// Register offsets, field positions, reset values and timing counts of the scrub host controller
`ifndef ESC_DEFINES_SVH
`define ESC_DEFINES_SVH
`define ESC_CLK_MHZ 200
`define ESC_OFF_CTRL 12'h000
`define ESC_OFF_CFG 12'h004
`define ESC_OFF_STATUS 12'h008
`define ESC_OFF_RDATA 12'h00c
`define ESC_CTRL_WRITE_CFG 0
`define ESC_CTRL_READ_CFG 1
`define ESC_CTRL_READ_CNT 2
`define ESC_CFG_RESET 13'h00a7
`define ESC_CFG_W 13
`define ESC_ADDR_W 19
`define ESC_A_READ_CFG 19'h00200
`define ESC_A_READ_CNT 19'h00480
// Strobe-to-data time in ps, rounded up to cycles
`define ESC_T_STROBE_DATA_PS 8200
`define ESC_STROBE_CYC ((`ESC_T_STROBE_DATA_PS * `ESC_CLK_MHZ + 999999) / 1000000)
// Setup time before strobe and strobe high time in ns
`define ESC_T_SETUP_NS 10
`define ESC_SETUP_CYC ((`ESC_T_SETUP_NS * `ESC_CLK_MHZ + 999) / 1000)
`define ESC_T_STROBE_HIGH_NS 15
`define ESC_HIGH_CYC ((`ESC_T_STROBE_HIGH_NS * `ESC_CLK_MHZ + 999) / 1000)
`endif

// [src/esc_pkg.sv]
// Types of the scrub host controller
package esc_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SETUP = 3'b001,
    ST_STROBE = 3'b010,
    ST_LOW = 3'b011,
    ST_DONE = 3'b100
  } esc_state_type;
  typedef struct packed {
    logic chip_select_low_active;
    logic chip_select_high_active;
    logic output_enable_n;
    logic write_enable_n;
    logic [18:0] addr;
    logic error_flag_out;
    logic error_flag_oe_n;
  } esc_pins_type;
  typedef struct packed {
    esc_state_type state;
    logic [7:0] cnt;
    logic [1:0] op;
    logic [12:0] cfg;
    logic [31:0] rdata;
    logic busy;
    logic configured;
    logic rd_valid;
    logic warn_seen;
    logic scrub_seen;
    logic prdata_valid;
    logic [31:0] prdata;
    esc_pins_type pins;
    logic w1;
    logic w2;
    logic s1;
    logic s2;
    logic f1;
    logic f2;
    logic [31:0] d1;
    logic [31:0] d2;
  } esc_state_reg_type;
endpackage

// [tb/esc_host_asserts.sv]
// Assertions on the device-side pins and array hold-off of the scrub host controller
`timescale 1ns/1ps
module esc_host_asserts (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Device pins and array hold-off
  input wire logic chip_select_low_active,
  input wire logic chip_select_high_active,
  input wire logic output_enable_n,
  input wire logic write_enable_n,
  input wire logic [18:0] addr,
  input wire logic error_flag_out,
  input wire logic error_flag_oe_n,
  input wire logic scrub_warning_n,
  input wire logic scrub_active_n,
  input wire logic array_blocked
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence setup_s;
    !error_flag_out ##1 !error_flag_out ##[1:3] error_flag_out;
  endsequence
  sequence strobe_s;
    error_flag_out [*8] ##1 !error_flag_out;
  endsequence
  pins_held_a: assert property (!chip_select_low_active |->
    write_enable_n && output_enable_n)
    else $error("output or write enable low during a control op");
  addr_stable_a: assert property (!chip_select_low_active &&
    $past(!chip_select_low_active) |-> $stable(addr))
    else $error("address moved during a control op");
  strobe_sel_a: assert property ($rose(error_flag_out) |->
    !chip_select_low_active && chip_select_high_active && !error_flag_oe_n)
    else $error("strobe without selects or drive");
  op_setup_a: assert property ($fell(chip_select_low_active) |-> setup_s)
    else $error("strobe setup wrong");
  strobe_hold_a: assert property ($rose(error_flag_out) |-> strobe_s)
    else $error("strobe width wrong");
  op_end_a: assert property ($fell(error_flag_out) |->
    !chip_select_low_active ##[2:4] $rose(chip_select_low_active))
    else $error("select not released after strobe");
  flag_release_a: assert property ($rose(chip_select_low_active) |-> error_flag_oe_n)
    else $error("flag still driven after op");
  blocked_set_a: assert property (!scrub_warning_n |-> ##2 array_blocked)
    else $error("array not blocked during warning");
endmodule
bind esc_host esc_host_asserts u_chk (.clk(clk), .rst_n(rst_n),
  .chip_select_low_active(chip_select_low_active),
  .chip_select_high_active(chip_select_high_active), .output_enable_n(output_enable_n),
  .write_enable_n(write_enable_n), .addr(addr), .error_flag_out(error_flag_out),
  .error_flag_oe_n(error_flag_oe_n), .scrub_warning_n(scrub_warning_n),
  .scrub_active_n(scrub_active_n), .array_blocked(array_blocked));

// [tb/esc_dev_model.sv]
// Behavioural SRAM: control register, scrub counter and scrub engine
`timescale 1ns/1ps
module esc_dev_model #(
  parameter real T_DATA = 8.2
) (
  // Control pins
  input wire logic cs_l_n,
  input wire logic cs_h,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic [18:0] a,
  input wire logic flag,
  // Data and scrub pins
  output logic [31:0] dq,
  output logic warn_n,
  output logic scrub_n
);
  logic [12:0] cfg = 13'h1900;
  logic [18:0] cnt = 19'h0;
  realtime t0 = 0;
  initial
  begin
    dq = 32'h0;
    warn_n = 1'b1;
    scrub_n = 1'b1;
  end
  always @(posedge flag)
  begin
    if (!cs_l_n && cs_h && oe_n && we_n)
    begin
      if (a[10:9] == 2'b00)
      begin
        cfg = a[12:0];
        cnt = '1;
        t0 = $realtime;
      end
      else if (!a[10])
        #T_DATA dq = {19'h2b6d3, cfg};
      else if (a[7])
        #T_DATA dq = {13'h15a9, cnt};
    end
  end
  // Released bus shows the inverse of its last value
  always @(posedge cs_l_n) dq = ~dq;
  always
  begin
    #5;
    // Interval stays at or above the listed minimum for codes 4 and up; codes 0 to 3 never scrub
    if (!cfg[8] && !cfg[11] && cfg[3:0] > 4'h3 &&
        $realtime - t0 >= (1400 << (cfg[3:0] - 4)))
    begin
      t0 = $realtime;
      warn_n = 1'b0;
      #(80 + 40 * cfg[7:4]);
      scrub_n = 1'b0;
      #200;
      cnt = cnt + 1'b1;
      scrub_n = 1'b1;
      #50;
      warn_n = 1'b1;
    end
  end
endmodule

// [tb/esc_host_test.sv]
// Self-checking bench of the scrub host controller
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin num_errors++; \
  $display("MISMATCH %0t %h %h", $time, a, e); end end
module esc_host_test;
  logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, dq_in, r;
  logic pready, pslverr, chip_select_low_active, chip_select_high_active, output_enable_n;
  logic write_enable_n, error_flag_out, error_flag_oe_n, scrub_warning_n, scrub_active_n;
  logic array_blocked;
  logic [18:0] addr;
  // Released flag line is pulled low, so release makes no strobe edge
  wire error_flag_in = error_flag_oe_n ? 1'b0 : error_flag_out;
  int num_errors = 0, checks = 0, nscrub = 0;
  logic [25:0] rows [3] = '{{13'h06b4, 13'h00b4}, {13'h1905, 13'h1905}, {13'h00a7, 13'h00a7}};
  always #2.5 clk = ~clk;
  always @(negedge scrub_active_n) nscrub++;
  esc_host u_dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .chip_select_low_active(chip_select_low_active),
    .chip_select_high_active(chip_select_high_active), .output_enable_n(output_enable_n),
    .write_enable_n(write_enable_n), .addr(addr), .error_flag_in(error_flag_in),
    .error_flag_out(error_flag_out), .error_flag_oe_n(error_flag_oe_n), .dq_in(dq_in),
    .scrub_warning_n(scrub_warning_n), .scrub_active_n(scrub_active_n),
    .array_blocked(array_blocked));
  esc_dev_model u_dev (.cs_l_n(chip_select_low_active), .cs_h(chip_select_high_active),
    .oe_n(output_enable_n), .we_n(write_enable_n), .a(addr), .flag(error_flag_in),
    .dq(dq_in), .warn_n(scrub_warning_n), .scrub_n(scrub_active_n));
  task automatic results;
    if (num_errors == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic stop;
    num_errors++;
    results();
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) stop();
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic ctrl(input logic [2:0] op);
    int n;
    n = 0;
    apb(1'b1, 12'h000, {29'h0, op});
    do
    begin
      apb(1'b0, 12'h008, 32'h0);
      n++;
    end
    while (r[0] !== 1'b0 && n < 50);
    if (r[0] !== 1'b0) stop();
  endtask
  initial
  begin
    int n;
    n = 0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, 12'h004, 32'h0);
    `CHK(r, 32'h000000a7)
    apb(1'b0, 12'h008, 32'h0);
    `CHK(r[1], 1'b0)
    foreach (rows[i])
    begin
      apb(1'b1, 12'h004, {19'h0, rows[i][25:13]});
      ctrl(3'b001);
      ctrl(3'b010);
      apb(1'b0, 12'h00c, 32'h0);
      `CHK(r[12:0], rows[i][12:0])
      ctrl(3'b100);
      apb(1'b0, 12'h00c, 32'h0);
      `CHK(r[18:0], 19'h7ffff)
    end
    apb(1'b1, 12'h004, 32'h4);
    ctrl(3'b001);
    nscrub = 0;
    while (array_blocked !== 1'b1 && n < 2000)
    begin
      @(posedge clk);
      n++;
    end
    if (array_blocked !== 1'b1) stop();
    // A control request during a scrub warning is refused
    apb(1'b1, 12'h000, 32'h2);
    apb(1'b0, 12'h008, 32'h0);
    `CHK(r[0], 1'b0)
    `CHK(r[5], 1'b1)
    n = 0;
    while ((nscrub < 2 || scrub_warning_n !== 1'b1) && n < 2000)
    begin
      @(posedge clk);
      n++;
    end
    if (nscrub < 2 || scrub_warning_n !== 1'b1) stop();
    apb(1'b0, 12'h008, 32'h0);
    `CHK(r[4:3], 2'b11)
    apb(1'b1, 12'h008, 32'h18);
    apb(1'b0, 12'h008, 32'h0);
    `CHK(r[4:3], 2'b00)
    ctrl(3'b100);
    apb(1'b0, 12'h00c, 32'h0);
    `CHK(r[18:0], 19'h00001)
    apb(1'b0, 12'h010, 32'h0);
    `CHK(r, 32'h0)
    `CHK(pslverr, 1'b0)
    results();
  end
endmodule
